// ==== hw/lpf_pkg.sv ====
/*
 * Constants, layouts and types of the LED fade / PWM block.
 * Assumes one system clock; register byte address is four times the index.
 */
package lpf_pkg;
    localparam int N_PINS = 8;
    localparam int LED_REGS = 5;
    localparam int ADDR_W = 10;
    localparam int CLK_HZ = 125_000_000;
    localparam int INT_OSC_HZ = 2_000_000;
    localparam int INT_OSC_DIV = CLK_HZ / INT_OSC_HZ;
    localparam logic [6:0] DIV_LAST = 7'(INT_OSC_DIV - 1);
    // register indexes
    localparam logic [7:0] IDX_POLARITY = 8'h06;
    localparam logic [7:0] IDX_DATA = 8'h08;
    localparam logic [7:0] IDX_MASK = 8'h09;
    localparam logic [7:0] IDX_SENSE_HI = 8'h0A;
    localparam logic [7:0] IDX_SENSE_LO = 8'h0B;
    localparam logic [7:0] IDX_IRQ_SRC = 8'h0C;
    localparam logic [7:0] IDX_CLOCK = 8'h0F;
    localparam logic [7:0] IDX_MISC = 8'h10;
    localparam logic [7:0] IDX_LED_EN = 8'h11;
    localparam logic [7:0] IDX_LED_BASE = 8'h40;
    // per-pin register fields
    localparam int F_ON_TIME = 0;
    localparam int F_ON_LEVEL = 1;
    localparam int F_OFF = 2;
    localparam int F_FADE_IN = 3;
    localparam int F_FADE_OUT = 4;
    // reset values and pin capabilities
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] ON_LVL_RST = 8'hFF;
    localparam logic [7:0] BLINK_PINS = 8'hCC;
    localparam logic [7:0] FADE_PINS = 8'h88;
    // clock_settings and misc_settings fields
    localparam int CLK_SRC_HI = 6;
    localparam int CLK_SRC_LO = 5;
    localparam int CLK_PIN_OUT = 4;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_INT = 2'h2;
    localparam logic [3:0] OUT_LOW = 4'h0;
    localparam logic [3:0] OUT_HIGH = 4'hF;
    localparam int MISC_LOG = 7;
    localparam int MISC_TICK_HI = 6;
    localparam int MISC_TICK_LO = 4;
    localparam int MISC_SYNC_RST = 2;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;

    localparam logic [7:0] LOG_TABLE [128] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h02, 8'h02, 8'h02, 8'h02, 8'h03, 8'h03, 8'h03, 8'h03,
        8'h04, 8'h04, 8'h05, 8'h05, 8'h06, 8'h06, 8'h07, 8'h07,
        8'h08, 8'h08, 8'h09, 8'h09, 8'h0A, 8'h0A, 8'h0B, 8'h0C,
        8'h0D, 8'h0D, 8'h0E, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13,
        8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B,
        8'h1C, 8'h1E, 8'h1F, 8'h20, 8'h22, 8'h23, 8'h24, 8'h26,
        8'h27, 8'h29, 8'h2A, 8'h2C, 8'h2E, 8'h2E, 8'h31, 8'h31,
        8'h35, 8'h35, 8'h38, 8'h38, 8'h3C, 8'h3C, 8'h41, 8'h41,
        8'h45, 8'h45, 8'h49, 8'h49, 8'h4E, 8'h4E, 8'h53, 8'h53,
        8'h58, 8'h58, 8'h5D, 8'h5D, 8'h62, 8'h62, 8'h68, 8'h68,
        8'h6E, 8'h6E, 8'h74, 8'h74, 8'h7A, 8'h7A, 8'h81, 8'h81,
        8'h87, 8'h87, 8'h8E, 8'h8E, 8'h96, 8'h96, 8'h9D, 8'h9D,
        8'hA5, 8'hA5, 8'hAC, 8'hAC, 8'hB5, 8'hB5, 8'hBD, 8'hBD,
        8'hC6, 8'hC6, 8'hCF, 8'hCF, 8'hD8, 8'hD8, 8'hE1, 8'hE1,
        8'hEB, 8'hEB, 8'hF5, 8'hF5, 8'hFF, 8'hFF, 8'hFF, 8'hFF
    };

    typedef enum logic [1:0] {PH_ON, PH_OFF, PH_DONE} lpf_phase_t;
    typedef logic [LED_REGS-1:0][7:0] lpf_led_cfg_t;
    typedef struct packed {
        lpf_phase_t phase;
        logic [7:0] level;
        logic [12:0] tcnt;
        logic [4:0] fcnt;
    } lpf_led_st_t;
    typedef struct packed {
        logic hit;
        logic [2:0] pin;
        logic [2:0] fld;
    } lpf_sel_t;
    typedef struct packed {
        logic aw_ok;
        logic [7:0] aw_idx;
        logic w_ok;
        logic w_en;
        logic [7:0] wb;
        logic bvalid;
        logic rvalid;
        logic [7:0] rdata;
        logic [7:0] polarity;
        logic [7:0] data;
        logic [7:0] mask;
        logic [7:0] sense_hi;
        logic [7:0] sense_lo;
        logic [7:0] irq_src;
        logic [7:0] clock;
        logic [7:0] misc;
        logic [7:0] led_en;
        logic [N_PINS-1:0] [LED_REGS-1:0][7:0] cfg;
        lpf_led_st_t [N_PINS-1:0] led;
        logic [6:0] osc_div;
        logic ext_q1;
        logic ext_q2;
        logic ext_q3;
        logic [7:0] io_q;
        logic [14:0] divcnt;
        logic [7:0] pwm;
        logic [N_PINS-1:0] pin_out;
        logic dco;
    } lpf_state_t;

    function automatic lpf_state_t lpf_rst_state();
        lpf_state_t s;
        s = '0;
        s.data = DATA_RST;
        s.mask = MASK_RST;
        // pins idle high during reset, so no false edge follows it
        s.io_q = DATA_RST;
        s.pin_out = DATA_RST;
        for (int i = 0; i < N_PINS; i++) begin
            s.cfg[i][F_ON_LEVEL] = ON_LVL_RST;
        end
        return s;
    endfunction

    function automatic lpf_sel_t led_sel(input logic [7:0] idx);
        lpf_sel_t s;
        logic [7:0] o;
        o = idx - IDX_LED_BASE;
        s.hit = idx >= IDX_LED_BASE && o < 8'(N_PINS * LED_REGS);
        s.pin = 3'(o / 8'(LED_REGS));
        s.fld = 3'(o % 8'(LED_REGS));
        return s;
    endfunction
endpackage

// ==== hw/lpf_led_fade.sv ====
/*
 * LED PWM / blink / fade drivers with clock management and the
 * open-drain interrupt combine, behind an AXI4-Lite register slave.
 * Assumes all inputs but ext_clock_in synchronous to aclk; keypad engine lives outside.
 */
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
// Operation
// - mask bit 0 enables edge; 01 is rising
// - interrupt low on edge event or keypad
// - all timing from main oscillator tick
// - source is off, internal or external
// - shared pin is clock input or output
// - clock output divides the main clock
// - clock output usable as plain output
// - one tick clock from misc bits 6:4
// - tick clock off after reset
// - driver runs only when enable bit set
// - on-time zero or no blink: static
// - on-time set, off-time zero: single shot
// - both times set: repeating blink
// - no fade support: level jumps
// - per-pin level, times and fade settings
// - misc selects linear or log per bank; here misc bit 7 alone sets it for every fade pin
// - log mode maps through fixed table
// - polarity never inverts the driven pin
// - reset input may clear counters only
// - data bit resets high, low starts driver
// - interrupt mask resets to all ones
`timescale 1ns/1ps
module lpf_led_fade
    import lpf_pkg::*;
#(
    parameter int TIME_UNIT = 256
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [N_PINS-1:0] io_in,
    input wire logic keypad_irq,
    input wire logic reset_in_low,
    input wire logic ext_clock_in,
    output logic divided_clock_out,
    output logic shared_osc_pin_oe,
    output logic main_osc_tick,
    output logic [N_PINS-1:0] led_pin_out,
    output logic irq_out_low
);
    localparam lpf_state_t ST_RST = lpf_rst_state();

    lpf_state_t st_reg;
    lpf_state_t st_next;
    logic osc_tick;
    logic led_tick;
    logic tick_on;
    logic [7:0] inten [N_PINS];

    function automatic logic div_hit(input logic [14:0] cnt,
                                     input logic [2:0] n);
        logic [14:0] m;
        m = 15'((15'h0001 << (n - 3'h1)) - 15'h0001);
        return (cnt & m) == m;
    endfunction

    function automatic logic [12:0] span(input logic [4:0] v);
        return 13'(32'(v) * TIME_UNIT - 1);
    endfunction

    assign awready = !st_reg.aw_ok;
    assign wready = !st_reg.w_ok;
    assign bvalid = st_reg.bvalid;
    assign bresp = RESP_OKAY;
    assign arready = !st_reg.rvalid;
    assign rvalid = st_reg.rvalid;
    assign rdata = {24'h000000, st_reg.rdata};
    assign rresp = RESP_OKAY;
    assign divided_clock_out = st_reg.dco;
    assign shared_osc_pin_oe = st_reg.clock[CLK_PIN_OUT];
    assign main_osc_tick = osc_tick;
    assign led_pin_out = st_reg.pin_out;
    assign irq_out_low = !(|st_reg.irq_src || keypad_irq);

    always_comb begin
        logic wr;
        logic [7:0] clr;
        logic [7:0] ev;
        logic [15:0] sense;
        logic [7:0] rb;
        lpf_sel_t ws;
        lpf_sel_t rs;
        logic [2:0] tsel;
        logic [3:0] osel;
        logic run;
        logic up;
        logic [4:0] ton;
        logic [4:0] toff;
        logic [4:0] lim;
        logic [4:0] ft;
        logic [7:0] offl;
        logic [7:0] tgt;
        wr = 1'b0;
        clr = '0;
        ev = '0;
        sense = {st_reg.sense_hi, st_reg.sense_lo};
        rb = '0;
        ws = led_sel(st_reg.aw_idx);
        rs = led_sel(araddr[ADDR_W-1:2]);
        tsel = st_reg.misc[MISC_TICK_HI:MISC_TICK_LO];
        osel = st_reg.clock[3:0];
        run = 1'b0;
        up = 1'b0;
        ton = '0;
        toff = '0;
        lim = '0;
        ft = '0;
        offl = '0;
        tgt = '0;
        st_next = st_reg;

        // write channel: address and data taken in either order
        if (awvalid && !st_reg.aw_ok) begin
            st_next.aw_ok = 1'b1;
            st_next.aw_idx = awaddr[ADDR_W-1:2];
        end
        if (wvalid && !st_reg.w_ok) begin
            st_next.w_ok = 1'b1;
            st_next.w_en = wstrb[0];
            st_next.wb = wdata[7:0];
        end
        if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid) begin
            wr = st_reg.w_en;
            st_next.aw_ok = 1'b0;
            st_next.w_ok = 1'b0;
            st_next.bvalid = 1'b1;
        end
        if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        if (wr) begin
            case (st_reg.aw_idx)
                IDX_POLARITY: st_next.polarity = st_reg.wb;
                IDX_DATA: st_next.data = st_reg.wb;
                IDX_MASK: st_next.mask = st_reg.wb;
                IDX_SENSE_HI: st_next.sense_hi = st_reg.wb;
                IDX_SENSE_LO: st_next.sense_lo = st_reg.wb;
                IDX_IRQ_SRC: clr = st_reg.wb;
                IDX_CLOCK: st_next.clock = st_reg.wb;
                IDX_MISC: st_next.misc = st_reg.wb;
                IDX_LED_EN: st_next.led_en = st_reg.wb;
                default: begin
                    if (ws.hit) begin
                        st_next.cfg[ws.pin][ws.fld] = st_reg.wb;
                    end
                end
            endcase
        end

        // read channel, one cycle latency
        case (araddr[ADDR_W-1:2])
            IDX_POLARITY: rb = st_reg.polarity;
            IDX_DATA: rb = st_reg.data;
            IDX_MASK: rb = st_reg.mask;
            IDX_SENSE_HI: rb = st_reg.sense_hi;
            IDX_SENSE_LO: rb = st_reg.sense_lo;
            IDX_IRQ_SRC: rb = st_reg.irq_src;
            IDX_CLOCK: rb = st_reg.clock;
            IDX_MISC: rb = st_reg.misc;
            IDX_LED_EN: rb = st_reg.led_en;
            default: rb = rs.hit ? st_reg.cfg[rs.pin][rs.fld] : '0;
        endcase
        if (arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rb;
        end
        if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end

        // edge events; a new event wins over a clear
        st_next.io_q = io_in;
        for (int i = 0; i < N_PINS; i++) begin
            ev[i] = !st_reg.mask[i]
                && ((sense[2*i] && io_in[i] && !st_reg.io_q[i])
                || (sense[2*i+1] && !io_in[i] && st_reg.io_q[i]));
        end
        st_next.irq_src = (st_reg.irq_src & ~clr) | ev;

        // main oscillator source
        st_next.osc_div = (st_reg.osc_div == DIV_LAST) ? '0
            : 7'(st_reg.osc_div + 7'h01);
        st_next.ext_q1 = ext_clock_in;
        st_next.ext_q2 = st_reg.ext_q1;
        st_next.ext_q3 = st_reg.ext_q2;
        case (st_reg.clock[CLK_SRC_HI:CLK_SRC_LO])
            SRC_INT: osc_tick = st_reg.osc_div == DIV_LAST;
            SRC_EXT: osc_tick = !st_reg.clock[CLK_PIN_OUT]
                && st_reg.ext_q2 && !st_reg.ext_q3;
            default: osc_tick = 1'b0;
        endcase
        if (osc_tick) begin
            st_next.divcnt = 15'(st_reg.divcnt + 15'h0001);
        end

        // clock output or plain level on the shared pin
        case (osel)
            OUT_LOW: st_next.dco = 1'b0;
            OUT_HIGH: st_next.dco = 1'b1;
            default: st_next.dco = st_reg.divcnt[osel - 4'h1];
        endcase

        // shared tick, off while its field is zero
        tick_on = tsel != '0;
        led_tick = osc_tick && tick_on && div_hit(st_reg.divcnt, tsel);
        if (led_tick) begin
            st_next.pwm = 8'(st_reg.pwm + 8'h01);
        end

        for (int i = 0; i < N_PINS; i++) begin
            run = tick_on && st_reg.led_en[i] && !st_reg.data[i];
            ton = BLINK_PINS[i] ? st_reg.cfg[i][F_ON_TIME][4:0] : '0;
            toff = BLINK_PINS[i] ? st_reg.cfg[i][F_OFF][7:3] : '0;
            offl = BLINK_PINS[i]
                ? {st_reg.cfg[i][F_OFF][2:0], 5'h00} : '0;
            tgt = !run ? '0 : (st_reg.led[i].phase == PH_ON)
                ? st_reg.cfg[i][F_ON_LEVEL] : offl;
            up = tgt > st_reg.led[i].level;
            ft = up ? st_reg.cfg[i][F_FADE_IN][4:0]
                : st_reg.cfg[i][F_FADE_OUT][4:0];
            lim = (st_reg.led[i].phase == PH_ON) ? ton : toff;
            if (led_tick) begin
                if (st_reg.led[i].level != tgt) begin
                    if (!FADE_PINS[i] || ft == '0) begin
                        st_next.led[i].level = tgt;
                    end else if (st_reg.led[i].fcnt >= 5'(ft - 5'h01)) begin
                        st_next.led[i].fcnt = '0;
                        st_next.led[i].level = up
                            ? 8'(st_reg.led[i].level + 8'h01)
                            : 8'(st_reg.led[i].level - 8'h01);
                    end else begin
                        st_next.led[i].fcnt = 5'(st_reg.led[i].fcnt + 5'h01);
                    end
                end else if (run && ton != '0
                        && st_reg.led[i].phase != PH_DONE) begin
                    if (lim == '0 || st_reg.led[i].tcnt >= span(lim)) begin
                        st_next.led[i].tcnt = '0;
                        if (st_reg.led[i].phase == PH_OFF) begin
                            st_next.led[i].phase = PH_ON;
                        end else if (toff == '0) begin
                            st_next.led[i].phase = PH_DONE;
                        end else begin
                            st_next.led[i].phase = PH_OFF;
                        end
                    end else begin
                        st_next.led[i].tcnt =
                            13'(st_reg.led[i].tcnt + 13'h0001);
                    end
                end
            end
            if (!run || ton == '0) begin
                st_next.led[i].phase = PH_ON;
                st_next.led[i].tcnt = '0;
            end
            inten[i] = (FADE_PINS[i] && st_reg.misc[MISC_LOG])
                ? LOG_TABLE[st_reg.led[i].level[7:1]]
                : st_reg.led[i].level;
            st_next.pin_out[i] = (tick_on && st_reg.led_en[i])
                ? !(st_reg.pwm < inten[i]) : st_reg.data[i];
        end

        // reset input: counters only, or the whole block
        if (!reset_in_low) begin
            if (st_reg.misc[MISC_SYNC_RST]) begin
                st_next.led = '0;
                st_next.pwm = '0;
                st_next.divcnt = '0;
                st_next.osc_div = '0;
            end else begin
                st_next = ST_RST;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_rise_irq;
        !st_reg.mask[1] && st_reg.sense_lo[3:2] == SENSE_RISE
            && !st_reg.io_q[1] && io_in[1] && reset_in_low
            |=> st_reg.irq_src[1] && !irq_out_low;
    endproperty
    a_rise_irq: assert property (p_rise_irq)
        else $error("rising edge did not raise interrupt");

    property p_mask_rst;
        $rose(aresetn) |-> st_reg.mask == MASK_RST && st_reg.data == DATA_RST;
    endproperty
    a_mask_rst: assert property (p_mask_rst)
        else $error("mask or data not all ones after reset");

    property p_tick_off;
        st_reg.misc[MISC_TICK_HI:MISC_TICK_LO] == '0 |-> !led_tick;
    endproperty
    a_tick_off: assert property (p_tick_off)
        else $error("led tick while tick clock off");

    property p_osc_off;
        st_reg.clock[CLK_SRC_HI:CLK_SRC_LO] == '0
            |-> !osc_tick ##1 $stable(st_reg.divcnt) || !reset_in_low;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("oscillator ran while source off");

    property p_disabled;
        !st_reg.led_en[0] && reset_in_low
            |=> led_pin_out[0] == $past(st_reg.data[0]);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled driver did not follow data bit");

    property p_static;
        st_reg.led[0].phase == PH_ON && st_reg.led[4].phase == PH_ON;
    endproperty
    a_static: assert property (p_static)
        else $error("non-blink pin left static mode");

    property p_single;
        st_reg.led[2].phase == PH_DONE && $stable(st_reg.cfg[2])
            && reset_in_low && !st_reg.data[2] && st_reg.led_en[2]
            && $stable(st_reg.data) && $stable(st_reg.led_en)
            && $stable(st_reg.misc) |=> st_reg.led[2].phase == PH_DONE;
    endproperty
    a_single: assert property (p_single)
        else $error("single shot restarted");

    property p_log;
        st_reg.misc[MISC_LOG] && st_reg.led[3].level[7:3] == 5'h1F
            |-> inten[3] == 8'hFF;
    endproperty
    a_log: assert property (p_log)
        else $error("log table top entry wrong");

    property p_fade;
        st_reg.cfg[3][F_FADE_IN][4:0] != '0 && reset_in_low
            && st_reg.led[3].level != 8'hFF
            |=> st_reg.led[3].level
                <= 8'($past(st_reg.led[3].level) + 8'h01);
    endproperty
    a_fade: assert property (p_fade)
        else $error("fade pin level jumped upward");

    property p_sync_rst;
        st_reg.misc[MISC_SYNC_RST] && !reset_in_low
            |=> st_reg.pwm == '0 && $stable(st_reg.cfg);
    endproperty
    a_sync_rst: assert property (p_sync_rst)
        else $error("counter reset lost settings");

    property p_gpo;
        st_reg.clock[3:0] == OUT_HIGH && reset_in_low
            |=> divided_clock_out;
    endproperty
    a_gpo: assert property (p_gpo)
        else $error("clock pin not held high as output");
endmodule

// ==== tb/lpf_pin_load.sv ====
/*
 * Far side of the LED block: open-drain pins with pull-ups and switches,
 * plus an external oscillator on the shared clock pin.
 * Assumes the bench drives pull_low and ext_run from its clock edges.
 */
`timescale 1ns/1ps
module lpf_pin_load
    import lpf_pkg::*;
(
    input wire logic [N_PINS-1:0] led_pin_out,
    input wire logic [N_PINS-1:0] pull_low,
    input wire logic shared_osc_pin_oe,
    input wire logic divided_clock_out,
    input wire logic ext_run,
    output logic [N_PINS-1:0] io_in,
    output logic ext_clock_in
);
    logic osc;
    // pulled up unless the driver or a switch sinks it
    assign io_in = led_pin_out & ~pull_low;
    // a driven shared pin reads back its own level
    assign ext_clock_in = shared_osc_pin_oe ? divided_clock_out
        : osc;
    // free oscillator, parked low while stopped
    initial begin
        osc = 1'b0;
        forever begin
            #37;
            osc = ext_run ? ~osc : 1'b0;
        end
    end
endmodule

// ==== tb/tb.sv ====
/*
 * Self-checking bench of the LED fade block with a register model.
 * Assumes lpf_pkg, the design and lpf_pin_load are compiled first.
 */
`timescale 1ns/1ps
module tb;
    import lpf_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, keypad_irq;
    logic reset_in_low, ext_clock_in, dco, oe, tick, irq_n, ext_run;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] rresp, bresp;
    logic [N_PINS-1:0] io_in, pins, pull_low;
    logic [7:0] lvl;
    logic [7:0] mdl [256];
    int mismatches, n_compared, seed, t, e, lo0, lo3, tr2, hi2;

    lpf_led_fade #(.TIME_UNIT(1)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .io_in(io_in),
        .keypad_irq(keypad_irq), .reset_in_low(reset_in_low),
        .ext_clock_in(ext_clock_in), .divided_clock_out(dco),
        .shared_osc_pin_oe(oe), .main_osc_tick(tick),
        .led_pin_out(pins), .irq_out_low(irq_n));
    lpf_pin_load i_load (.led_pin_out(pins), .pull_low(pull_low),
        .shared_osc_pin_oe(oe), .divided_clock_out(dco),
        .ext_run(ext_run), .io_in(io_in), .ext_clock_in(ext_clock_in));

    task automatic end_sim();
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic bit mapped(input logic [7:0] i);
        return i inside {8'h06, [8'h08:8'h0C], [8'h0F:8'h11]}
            || (i >= 8'h40 && i < 8'h68);
    endfunction
    task automatic mreset();
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[IDX_DATA] = 8'hFF;
        mdl[IDX_MASK] = 8'hFF;
        for (int p = 0; p < N_PINS; p++) mdl[8'(8'h41 + 5 * p)] = 8'hFF;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic a, w, b;
        logic [1:0] rs;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            #1;
            a = awvalid & awready;
            w = wvalid & wready;
            b = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
        if (mapped(idx)) mdl[idx] = d;
        chk(32'(rs), 32'(RESP_OKAY));
    endtask
    task automatic rchk(input logic [7:0] idx);
        logic a, r;
        logic [31:0] d;
        logic [1:0] rs;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        r = 1'b0;
        while (!r) begin
            #1;
            a = arvalid & arready;
            r = rvalid;
            d = rdata;
            rs = rresp;
            @(posedge aclk);
            if (a) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
        end
        chk(d, {24'h0, mdl[idx]});
        chk(32'(rs), 32'(RESP_OKAY));
    endtask
    task automatic pl(input logic [7:0] v);
        @(posedge aclk);
        pull_low <= v;
        wt(3);
    endtask
    task automatic rst_pulse();
        @(posedge aclk);
        reset_in_low <= 1'b0;
        wt(3);
        reset_in_low <= 1'b1;
        wt(2);
    endtask
    task automatic clk_cnt(input int cyc);
        logic p;
        t = 0;
        e = 0;
        p = dco;
        repeat (cyc) begin
            @(posedge aclk);
            #1;
            t += int'(tick === 1'b1);
            e += int'(dco === 1'b1 && p === 1'b0);
            p = dco;
        end
    endtask
    task automatic led_ticks(input int n);
        int k;
        logic p;
        k = 0;
        lo0 = 0;
        lo3 = 0;
        tr2 = 0;
        hi2 = 0;
        p = pins[2];
        while (k < n) begin
            @(posedge aclk);
            #1;
            if (tick === 1'b1) begin
                k++;
                lo0 += int'(pins[0] === 1'b0);
                lo3 += int'(pins[3] === 1'b0);
                hi2 += int'(pins[2] === 1'b1);
                tr2 += int'(pins[2] !== p);
                p = pins[2];
            end
        end
    endtask

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        repeat (60000) @(posedge aclk);
        mismatches++;
        end_sim();
    end
    initial begin
        seed = 32'h4750;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {keypad_irq, ext_run, awaddr, araddr, wdata, pull_low} = '0;
        reset_in_low = 1'b1;
        mreset();
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        wt(1);
        chk(32'(pins), 32'hFF);
        rchk(IDX_MASK);
        rchk(IDX_DATA);
        rchk(IDX_MISC);
        wr(8'h30, 8'h5A);
        rchk(8'h30);
        wr(IDX_MASK, 8'hFD);
        wr(IDX_SENSE_LO, 8'h05);
        pl(8'h03);
        chk(32'(irq_n), 32'h1);
        pl(8'h02);
        chk(32'(irq_n), 32'h1);
        pl(8'h00);
        chk(32'(irq_n), 32'h0);
        wr(IDX_IRQ_SRC, 8'hFF);
        wt(2);
        chk(32'(irq_n), 32'h1);
        keypad_irq <= 1'b1;
        wt(1);
        chk(32'(irq_n), 32'h0);
        keypad_irq <= 1'b0;
        wr(IDX_CLOCK, 8'h1F);
        wt(2);
        chk(32'({oe, dco}), 32'h3);
        wr(IDX_CLOCK, 8'h10);
        wt(2);
        chk(32'({oe, dco}), 32'h2);
        clk_cnt(200);
        chk(32'(t), 32'h0);
        wr(IDX_CLOCK, 8'h51);
        wt(130);
        clk_cnt(1240);
        chk(32'(t), 32'd20);
        chk(32'(e), 32'd10);
        wr(IDX_CLOCK, 8'h20);
        ext_run <= 1'b1;
        clk_cnt(200);
        chk(32'(t >= 20 && t <= 23), 32'h1);
        ext_run <= 1'b0;
        wt(20);
        clk_cnt(100);
        chk(32'(t), 32'h0);
        wr(IDX_CLOCK, 8'h40);
        lvl = 8'($random(seed));
        wr(8'h41, lvl);
        rchk(8'h41);
        wr(8'h50, 8'h80);
        wr(8'h55, 8'h00);
        wr(8'h4A, 8'h01);
        wr(8'h4C, 8'h08);
        wr(IDX_LED_EN, 8'h0D);
        wr(IDX_DATA, 8'hE2);
        wt(3);
        chk(32'(pins), 32'hE2);
        wr(IDX_POLARITY, 8'hFF);
        wt(3);
        chk(32'(pins), 32'hE2);
        wr(IDX_MISC, 8'h90);
        led_ticks(4);
        led_ticks(256);
        chk(32'(lo0), {24'h0, lvl});
        chk(32'(lo3), 32'd53);
        chk(32'(tr2 >= 4), 32'h1);
        chk(32'({pins[4], pins[1]}), 32'h1);
        wr(8'h52, 8'h01);
        wr(8'h50, 8'hFC);
        wr(8'h4C, 8'h00);
        led_ticks(64);
        led_ticks(32);
        chk(32'(hi2), 32'd32);
        wr(8'h4A, 8'h00);
        led_ticks(4);
        led_ticks(32);
        chk(32'(hi2 <= 1), 32'h1);
        wr(IDX_MISC, 8'h94);
        rst_pulse();
        rchk(8'h41);
        rchk(IDX_MISC);
        wr(IDX_MISC, 8'h90);
        rst_pulse();
        mreset();
        rchk(IDX_MASK);
        rchk(IDX_MISC);
        chk(32'(pins), 32'hFF);
        end_sim();
    end
endmodule
